// ---- dpp_pkg.sv ----
/*
 dual parallel port: constants, types, reset values.
 assumes one core clock; every pin is synchronised inside the top.
*/
// Function
// - bidirectional mode is accepted only on the first port
// - each port holds input, output, mode, mask, direction, mask logic registers
// - data write in output mode loads the output register
// - ready rises on the cycle after an output data write
// - output ready holds until the peripheral latch pulse rises
// - output latch pulse rise requests interrupt when enabled and chain allows
// - input mode loads port lines while latch pulse is low
// - input latch pulse rise requests interrupt when enabled and chain allows
// - input latch pulse rise drops ready: input register full
// - end of host data read raises ready on the next cycle
// - bit mode read mixes output bits and input bits by direction
// - bit mode captures port lines just before the read starts
// - bit mode requests interrupt when enabled unmasked lines match condition
// - pending status seen by the chain is frozen during opcode fetch
// - only the granted device drives its vector in the acknowledge cycle
// - after acknowledge, chain out stays low until service return
// - idle: chain out follows chain in; under service: chain out low
// - pending unacknowledged: chain out low, high only after prefix byte
// - second byte 4D with chain in high ends service
// - mode word: mode in bits 7 and 6, low nibble 1111
// - mode codes: 00 output, 01 input, 10 bidirectional, 11 bit
// - after bit mode the next control word sets line directions, 1 input
// - a control word with bit 0 low loads the port interrupt vector
// - interrupt word: enable bit 7, logic bits 6 and 5, fixed low nibble
// - mask-follows bit makes the next control word the mask
// - only lines with mask bit 0 take part in the condition
// - short command changes only the interrupt enable
package dpp_pkg;
    localparam logic [3:0] DPP_CW_MODE = 4'hF;
    localparam logic [3:0] DPP_CW_INTCTL = 4'h7;
    localparam logic [3:0] DPP_CW_INTEN = 4'h3;
    localparam logic [7:0] DPP_OP_PREFIX = 8'hED;
    localparam logic [7:0] DPP_OP_RETURN = 8'h4D;
    localparam int DPP_IE_BIT = 7;
    localparam int DPP_FOLLOW_BIT = 4;
    localparam logic [7:0] DPP_RST_MASK = 8'hFF;
    localparam logic [7:0] DPP_RST_DIR = 8'hFF;
    localparam logic [7:0] DPP_RST_VEC = 8'h00;
    typedef enum logic [1:0] {
        DPP_MODE_OUT = 2'b00,
        DPP_MODE_IN = 2'b01,
        DPP_MODE_BIDIR = 2'b10,
        DPP_MODE_BIT = 2'b11
    } dpp_mode_t;
    typedef enum logic [1:0] {
        DPP_EXP_NONE = 2'b00,
        DPP_EXP_DIR = 2'b01,
        DPP_EXP_MASK = 2'b10
    } dpp_expect_t;
    typedef struct packed {
        logic [7:0] data;
        logic cs_n;
        logic ctrl;
        logic psel;
        logic rd_n;
        logic host_port_request_n;
        logic m1_n;
        logic priority_chain_in;
        logic [1:0] stb_n;
        logic [1:0][7:0] line;
    } dpp_pins_t;
    typedef struct packed {
        logic [7:0] in_latch;
        logic [7:0] out_latch;
        dpp_mode_t mode;
        logic [7:0] mask;
        logic [7:0] dir;
        logic [1:0] mlogic;
        logic ie;
        dpp_expect_t cw_follow;
        logic [7:0] vec;
        logic ready;
        logic pend;
        logic srv;
        logic match;
        logic [7:0] lout;
        logic [7:0] loe;
    } dpp_port_t;
    localparam dpp_port_t DPP_PORT_RST = '{mode: DPP_MODE_IN,
        mask: DPP_RST_MASK, dir: DPP_RST_DIR, vec: DPP_RST_VEC,
        cw_follow: DPP_EXP_NONE, default: '0};
    typedef struct packed {
        dpp_pins_t s1;
        dpp_pins_t s2;
        dpp_pins_t s3;
        dpp_pins_t filt;
        dpp_pins_t prev;
        dpp_port_t [1:0] port;
        logic [1:0] vis;
        logic ed;
        logic own_v;
        logic own;
        logic priority_chain_out;
        logic int_oe;
        logic [7:0] dout;
        logic doe;
    } dpp_state_t;
endpackage

// ---- dpp_top.sv ----
/*
 dual eight-bit parallel port with handshake and daisy-chain vectoring.
 assumes host bus strobes and peripheral lines are asynchronous pins;
 open-drain interrupt is out/enable, the board resolves the wire.
*/
module dpp_top (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic [7:0] HOST_DATA_IN,
    output logic [7:0] HOST_DATA_OUT,
    output logic HOST_DATA_OE,
    input wire logic HOST_CHIP_SEL_N,
    input wire logic HOST_CTRL_SEL,
    input wire logic HOST_PORT_SEL,
    input wire logic HOST_READ_N,
    input wire logic HOST_PORT_REQUEST_N,
    input wire logic OPCODE_FETCH_CYCLE_N,
    input wire logic PRIORITY_CHAIN_IN,
    output logic PRIORITY_CHAIN_OUT,
    output logic INT_REQ_OUT,
    output logic INT_REQ_OE,
    input wire logic [7:0] FIRST_PORT_DATA_IN,
    output logic [7:0] FIRST_PORT_DATA_OUT,
    output logic [7:0] FIRST_PORT_DATA_OE,
    input wire logic FIRST_PORT_LATCH_PULSE_N,
    output logic FIRST_PORT_READY,
    input wire logic [7:0] SECOND_PORT_DATA_IN,
    output logic [7:0] SECOND_PORT_DATA_OUT,
    output logic [7:0] SECOND_PORT_DATA_OE,
    input wire logic SECOND_PORT_LATCH_PULSE_N,
    output logic SECOND_PORT_READY
);
    import dpp_pkg::*;

    localparam dpp_state_t DPP_STATE_RST = '{s1: '1, s2: '1, s3: '1,
        filt: '1, prev: '1, port: {DPP_PORT_RST, DPP_PORT_RST},
        default: '0};

    dpp_state_t q;
    dpp_state_t d;
    dpp_pins_t pins;
    dpp_pins_t f;
    dpp_pins_t p;
    logic rd_act;
    logic rd_act_p;
    logic rd_start;
    logic rd_end;
    logic wr_ev;
    logic ack_act;
    logic ack_act_p;
    logic ack_start;
    logic fetch_end;
    logic [1:0] stb_rise;
    logic [1:0] cw_ev;
    logic [1:0] dw_ev;
    logic [1:0] re_ev;

    always_comb
    begin
        pins.data = HOST_DATA_IN;
        pins.cs_n = HOST_CHIP_SEL_N;
        pins.ctrl = HOST_CTRL_SEL;
        pins.psel = HOST_PORT_SEL;
        pins.rd_n = HOST_READ_N;
        pins.host_port_request_n = HOST_PORT_REQUEST_N;
        pins.m1_n = OPCODE_FETCH_CYCLE_N;
        pins.priority_chain_in = PRIORITY_CHAIN_IN;
        pins.stb_n = {SECOND_PORT_LATCH_PULSE_N, FIRST_PORT_LATCH_PULSE_N};
        pins.line = {SECOND_PORT_DATA_IN, FIRST_PORT_DATA_IN};
    end

    assign f = q.filt;
    assign p = q.prev;
    // host cycle decode on filtered levels; write taken at its trailing edge
    assign rd_act = ~f.cs_n & ~f.host_port_request_n & ~f.rd_n & f.m1_n;
    assign rd_act_p = ~p.cs_n & ~p.host_port_request_n & ~p.rd_n & p.m1_n;
    assign rd_start = rd_act & ~rd_act_p;
    assign rd_end = rd_act_p & ~rd_act;
    assign wr_ev = ~p.host_port_request_n & f.host_port_request_n & ~p.cs_n & p.rd_n & p.m1_n;
    assign ack_act = ~f.m1_n & ~f.host_port_request_n;
    assign ack_act_p = ~p.m1_n & ~p.host_port_request_n;
    assign ack_start = ack_act & ~ack_act_p;
    assign fetch_end = ~p.m1_n & ~p.rd_n & p.host_port_request_n & ~(~f.m1_n & ~f.rd_n);

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_ev
            assign stb_rise[g] = ~p.stb_n[g] & f.stb_n[g];
            assign cw_ev[g] = wr_ev & p.ctrl & (p.psel == 1'(g));
            assign dw_ev[g] = wr_ev & ~p.ctrl & (p.psel == 1'(g));
            assign re_ev[g] = rd_end & ~p.ctrl & (p.psel == 1'(g));
        end
    endgenerate

    always_comb
    begin
        logic [7:0] act;
        logic hit;
        logic [7:0] rv;
        dpp_mode_t nm;
        act = '0;
        hit = 1'b0;
        rv = '0;
        nm = DPP_MODE_OUT;
        d = q;
        // three-stage synchroniser, change accepted once stages 2 and 3 agree
        d.s1 = pins;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.filt = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.filt);
        d.prev = q.filt;
        if (f.m1_n)
        begin
            d.vis = {q.port[1].pend, q.port[0].pend};
        end
        if (~ack_act)
        begin
            d.own_v = 1'b0;
        end
        if (ack_start & f.priority_chain_in)
        begin
            // internal chain: first port ahead of second
            if (q.vis[0] & ~q.port[0].srv)
            begin
                d.own_v = 1'b1;
                d.own = 1'b0;
            end
            else if (q.vis[1] & ~q.port[1].srv & ~q.port[0].srv)
            begin
                d.own_v = 1'b1;
                d.own = 1'b1;
            end
            if (d.own_v)
            begin
                d.port[d.own].srv = 1'b1;
                d.port[d.own].pend = 1'b0;
            end
        end
        d.ed = q.ed;
        if (fetch_end)
        begin
            if (q.ed)
            begin
                d.ed = 1'b0;
                if (p.data == DPP_OP_RETURN && f.priority_chain_in)
                begin
                    if (q.port[0].srv)
                    begin
                        d.port[0].srv = 1'b0;
                    end
                    else
                    begin
                        d.port[1].srv = 1'b0;
                    end
                end
            end
            else if (p.data == DPP_OP_PREFIX)
            begin
                d.ed = 1'b1;
            end
        end
        for (int i = 0; i < 2; i++)
        begin
            if (dw_ev[i])
            begin
                d.port[i].out_latch = p.data;
                if (q.port[i].mode == DPP_MODE_OUT || q.port[i].mode == DPP_MODE_BIDIR)
                begin
                    d.port[i].ready = 1'b1;
                end
            end
            if (cw_ev[i])
            begin
                case (q.port[i].cw_follow)
                    DPP_EXP_DIR:
                    begin
                        d.port[i].dir = p.data;
                        d.port[i].cw_follow = DPP_EXP_NONE;
                    end
                    DPP_EXP_MASK:
                    begin
                        d.port[i].mask = p.data;
                        d.port[i].cw_follow = DPP_EXP_NONE;
                    end
                    default:
                    begin
                        nm = dpp_mode_t'(p.data[7:6]);
                        if (!p.data[0])
                        begin
                            d.port[i].vec = {p.data[7:1], 1'b0};
                        end
                        else if (p.data[3:0] == DPP_CW_MODE)
                        begin
                            if (!(i == 1 && nm == DPP_MODE_BIDIR))
                            begin
                                d.port[i].mode = nm;
                                d.port[i].ready = (nm == DPP_MODE_IN);
                                if (nm == DPP_MODE_BIT)
                                begin
                                    d.port[i].cw_follow = DPP_EXP_DIR;
                                end
                            end
                        end
                        else if (p.data[3:0] == DPP_CW_INTCTL)
                        begin
                            d.port[i].ie = p.data[DPP_IE_BIT];
                            d.port[i].mlogic = p.data[6:5];
                            if (p.data[DPP_FOLLOW_BIT])
                            begin
                                d.port[i].cw_follow = DPP_EXP_MASK;
                            end
                        end
                        else if (p.data[3:0] == DPP_CW_INTEN)
                        begin
                            d.port[i].ie = p.data[DPP_IE_BIT];
                        end
                    end
                endcase
            end
            // mlogic[1]: and of all unmasked lines, mlogic[0]: active high
            act = q.port[i].mlogic[0] ? f.line[i] : ~f.line[i];
            if (q.port[i].mlogic[1])
            begin
                hit = (&(act | q.port[i].mask)) & ~(&q.port[i].mask);
            end
            else
            begin
                hit = |(act & ~q.port[i].mask);
            end
            d.port[i].match = hit & (q.port[i].mode == DPP_MODE_BIT);
            case (q.port[i].mode)
                DPP_MODE_OUT:
                begin
                    if (stb_rise[i])
                    begin
                        d.port[i].ready = 1'b0;
                        d.port[i].pend = d.port[i].pend | q.port[i].ie;
                    end
                    d.port[i].lout = q.port[i].out_latch;
                    d.port[i].loe = '1;
                end
                DPP_MODE_IN:
                begin
                    if (~f.stb_n[i])
                    begin
                        d.port[i].in_latch = f.line[i];
                    end
                    if (re_ev[i])
                    begin
                        d.port[i].ready = 1'b1;
                    end
                    if (stb_rise[i])
                    begin
                        d.port[i].ready = 1'b0;
                        d.port[i].pend = d.port[i].pend | q.port[i].ie;
                    end
                    d.port[i].loe = '0;
                end
                DPP_MODE_BIDIR:
                begin
                    // lines driven only while the peripheral pulls the pulse low
                    if (stb_rise[i])
                    begin
                        d.port[i].ready = 1'b0;
                        d.port[i].pend = d.port[i].pend | q.port[i].ie;
                        d.port[i].in_latch = p.line[i];
                    end
                    d.port[i].lout = q.port[i].out_latch;
                    d.port[i].loe = f.stb_n[i] ? 8'h00 : 8'hFF;
                end
                default:
                begin
                    if (rd_start & ~f.ctrl & (f.psel == i[0]))
                    begin
                        d.port[i].in_latch = p.line[i];
                    end
                    if (hit & ~q.port[i].match & q.port[i].ie)
                    begin
                        d.port[i].pend = 1'b1;
                    end
                    d.port[i].lout = q.port[i].out_latch;
                    d.port[i].loe = ~q.port[i].dir;
                end
            endcase
        end
        // chain out from frozen pending view; prefix byte opens it briefly
        d.priority_chain_out = f.priority_chain_in & ~(d.port[0].srv | d.port[1].srv) &
            (~(d.vis[0] | d.vis[1]) | d.ed);
        d.int_oe = f.priority_chain_in & ((d.port[0].pend & ~d.port[0].srv) |
            (d.port[1].pend & ~d.port[1].srv & ~d.port[0].srv));
        case (d.port[f.psel].mode)
            DPP_MODE_OUT: rv = d.port[f.psel].out_latch;
            DPP_MODE_BIT: rv = (d.port[f.psel].out_latch & ~d.port[f.psel].dir) |
                (d.port[f.psel].in_latch & d.port[f.psel].dir);
            default: rv = d.port[f.psel].in_latch;
        endcase
        d.doe = (rd_act & ~f.ctrl) | (ack_act & d.own_v);
        d.dout = (ack_act & d.own_v) ? d.port[d.own].vec : rv;
    end

    always_ff @(posedge CORE_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            q <= DPP_STATE_RST;
        end
        else
        begin
            q <= d;
        end
    end

    assign HOST_DATA_OUT = q.dout;
    assign HOST_DATA_OE = q.doe;
    assign PRIORITY_CHAIN_OUT = q.priority_chain_out;
    assign INT_REQ_OUT = 1'b0;
    assign INT_REQ_OE = q.int_oe;
    assign FIRST_PORT_DATA_OUT = q.port[0].lout;
    assign FIRST_PORT_DATA_OE = q.port[0].loe;
    assign FIRST_PORT_READY = q.port[0].ready;
    assign SECOND_PORT_DATA_OUT = q.port[1].lout;
    assign SECOND_PORT_DATA_OE = q.port[1].loe;
    assign SECOND_PORT_READY = q.port[1].ready;

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (SYS_RST);

    sequence s_out_write;
        dw_ev[0] && q.port[0].mode == DPP_MODE_OUT;
    endsequence
    sequence s_ready_shown;
        ##1 FIRST_PORT_READY && q.port[0].out_latch == $past(p.data);
    endsequence
    property p_write_ready;
        s_out_write |-> s_ready_shown;
    endproperty
    a_write_ready: assert property (p_write_ready)
        else $error("output write did not raise ready with data");

    property p_ready_hold;
        FIRST_PORT_READY && q.port[0].mode == DPP_MODE_OUT && !stb_rise[0]
            && !cw_ev[0] |=> FIRST_PORT_READY;
    endproperty
    a_ready_hold: assert property (p_ready_hold)
        else $error("output ready dropped without latch pulse");

    property p_in_full;
        stb_rise[1] && q.port[1].mode == DPP_MODE_IN && !cw_ev[1] && !ack_start
            |=> !SECOND_PORT_READY && q.port[1].pend == $past(q.port[1].ie
            || q.port[1].pend);
    endproperty
    a_in_full: assert property (p_in_full)
        else $error("input latch pulse did not fill port");

    property p_read_ready;
        re_ev[1] && q.port[1].mode == DPP_MODE_IN && !stb_rise[1]
            && !cw_ev[1] |=> SECOND_PORT_READY;
    endproperty
    a_read_ready: assert property (p_read_ready)
        else $error("read end did not raise ready");

    property p_in_load;
        q.port[1].mode == DPP_MODE_IN && !f.stb_n[1] && !cw_ev[1]
            |=> q.port[1].in_latch == $past(f.line[1]);
    endproperty
    a_in_load: assert property (p_in_load)
        else $error("input register not following lines");

    property p_no_bidir_b;
        cw_ev[1] && q.port[1].cw_follow == DPP_EXP_NONE
            && p.data == {DPP_MODE_BIDIR, 2'b00, DPP_CW_MODE}
            |=> $stable(q.port[1].mode);
    endproperty
    a_no_bidir_b: assert property (p_no_bidir_b)
        else $error("second port took bidirectional mode");

    property p_frozen;
        !f.m1_n |=> $stable(q.vis);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("pending view moved during fetch");

    sequence s_grant;
        ack_start && f.priority_chain_in && q.vis[0] && !q.port[0].srv;
    endsequence
    property p_grant;
        s_grant |=> q.port[0].srv && q.own_v ##1 !PRIORITY_CHAIN_OUT
            && HOST_DATA_OUT == q.port[0].vec;
    endproperty
    a_grant: assert property (p_grant)
        else $error("acknowledge grant misbehaved");

    property p_pass;
        f.priority_chain_in && !d.port[0].srv && !d.port[1].srv && !d.vis[0]
            && !d.vis[1] |=> PRIORITY_CHAIN_OUT;
    endproperty
    a_pass: assert property (p_pass)
        else $error("idle chain out not following chain in");

    property p_prefix;
        fetch_end && !q.ed && p.data == DPP_OP_PREFIX |=> q.ed;
    endproperty
    a_prefix: assert property (p_prefix)
        else $error("prefix byte not seen");

    property p_return;
        fetch_end && q.ed && p.data == DPP_OP_RETURN && f.priority_chain_in
            && q.port[0].srv |=> !q.port[0].srv;
    endproperty
    a_return: assert property (p_return)
        else $error("service return did not clear service");

    property p_bit_int;
        q.port[1].mode == DPP_MODE_BIT && d.port[1].match
            && !q.port[1].match && q.port[1].ie && !ack_start
            |=> q.port[1].pend;
    endproperty
    a_bit_int: assert property (p_bit_int)
        else $error("bit mode match did not request");
endmodule // dpp_top

// ---- dpp_periph.sv ----
/*
 peripheral model for one port: latch pulse and data lines.
 assumes the bench resolves each line from the device's per-line enable.
*/
module dpp_periph (
    input wire logic clk,
    output logic [7:0] line,
    output logic stb_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic drv = 1'b0;
    logic [7:0] val = 8'h00;
    initial stb_n = 1'b1;
    // released lines toggle every cycle so a stale value never looks valid
    always @(posedge clk)
    begin
        if (!drv)
            val <= ~val;
    end
    assign line = val;
    task automatic drive(input logic [7:0] d);
        drv = 1'b1;
        val = d;
    endtask
    // low_cyc sets a prompt or a slow peripheral
    task automatic pulse(input logic [7:0] d, input int low_cyc);
        drive(d);
        stb_n = 1'b0;
        repeat (low_cyc) @(posedge clk);
        #1;
        stb_n = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        drv = 1'b0;
    endtask
endmodule // dpp_periph

// ---- dpp_top_bench.sv ----
/*
 self-checking bench for the dual parallel port, with a byte-level model.
 assumes 3-flop pin sync and at least 5 cycles between host requests.
*/
module dpp_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import dpp_pkg::*;
    logic clk, rst, cs_n, ctrl, psel, rd_n, req_n, m1_n, cin;
    logic [7:0] hd, v, r, o, l;
    wire hoe, cout, iro, iroe;
    wire [7:0] hdo;
    wire [1:0][7:0] pdo, poe, pln, pin;
    wire [1:0] rdy, stb;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int md[2] = '{1, 1};
    int nxt[2] = '{0, 0};
    logic [7:0] dir[2] = '{8'hFF, 8'hFF};
    logic [7:0] outl[2] = '{8'h00, 8'h00};
    logic [7:0] inl[2] = '{8'h00, 8'h00};
    dpp_top dut (.CORE_CLK(clk), .SYS_RST(rst), .HOST_DATA_IN(hd), .HOST_DATA_OUT(hdo),
        .HOST_DATA_OE(hoe), .HOST_CHIP_SEL_N(cs_n), .HOST_CTRL_SEL(ctrl),
        .HOST_PORT_SEL(psel), .HOST_READ_N(rd_n), .HOST_PORT_REQUEST_N(req_n),
        .OPCODE_FETCH_CYCLE_N(m1_n), .PRIORITY_CHAIN_IN(cin), .PRIORITY_CHAIN_OUT(cout),
        .INT_REQ_OUT(iro), .INT_REQ_OE(iroe), .FIRST_PORT_DATA_IN(pin[0]),
        .FIRST_PORT_DATA_OUT(pdo[0]), .FIRST_PORT_DATA_OE(poe[0]),
        .FIRST_PORT_LATCH_PULSE_N(stb[0]), .FIRST_PORT_READY(rdy[0]),
        .SECOND_PORT_DATA_IN(pin[1]), .SECOND_PORT_DATA_OUT(pdo[1]),
        .SECOND_PORT_DATA_OE(poe[1]), .SECOND_PORT_LATCH_PULSE_N(stb[1]),
        .SECOND_PORT_READY(rdy[1]));
    dpp_periph p0 (.clk(clk), .line(pln[0]), .stb_n(stb[0]));
    dpp_periph p1 (.clk(clk), .line(pln[1]), .stb_n(stb[1]));
    assign pin[0] = (poe[0] & pdo[0]) | (~poe[0] & pln[0]);
    assign pin[1] = (poe[1] & pdo[1]) | (~poe[1] & pln[1]);
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic report_and_stop();
        $display("compares %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            fail_count++;
            $display("Error at %0t: run did not finish", $time);
            report_and_stop();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic bus(input logic c, t, s, rn, mn, qn, input logic [7:0] d);
        cs_n = c;
        ctrl = t;
        psel = s;
        rd_n = rn;
        m1_n = mn;
        req_n = qn;
        hd = d;
    endtask
    // byte model of the control word decoder
    task automatic model_ctl(input int s, input logic [7:0] d);
        if (nxt[s] != 0)
        begin
            if (nxt[s] == 1)
                dir[s] = d;
            nxt[s] = 0;
        end
        else if (d[0] && d[3:0] == 4'hF && !(s == 1 && d[7:6] == 2'b10))
        begin
            md[s] = d[7:6];
            nxt[s] = (md[s] == 3) ? 1 : 0;
        end
        else if (d[3:0] == 4'h7 && d[4])
            nxt[s] = 2;
    endtask
    function automatic logic [7:0] exp_rd(input int s, input logic [7:0] ln);
        if (md[s] == 0)
            return outl[s];
        if (md[s] == 3)
            return (dir[s] & ln) | (~dir[s] & outl[s]);
        return inl[s];
    endfunction
    task automatic wr(input logic c, s, input logic [7:0] d);
        bus(1'b0, c, s, 1'b1, 1'b1, 1'b0, d);
        tick(5);
        req_n = 1'b1;
        tick(6);
        cs_n = 1'b1;
        tick(1);
        if (c)
            model_ctl(s, d);
        else
            outl[s] = d;
    endtask
    task automatic rd(input logic s, input logic [7:0] e);
        bus(1'b0, 1'b0, s, 1'b0, 1'b1, 1'b0, 8'h00);
        tick(6);
        chk({7'h00, hoe}, 8'h01);
        chk(hdo, e);
        bus(1'b0, 1'b0, s, 1'b1, 1'b1, 1'b1, 8'h00);
        tick(6);
        cs_n = 1'b1;
        tick(1);
    endtask
    task automatic op(input logic [7:0] d);
        bus(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, d);
        tick(5);
        bus(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, d);
        tick(6);
    endtask
    task automatic service(input logic [7:0] e);
        chk({7'h00, cout}, 8'h00);
        op(DPP_OP_PREFIX);
        chk({7'h00, cout}, 8'h01);
        op(8'h00);
        chk({7'h00, cout}, 8'h00);
        bus(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00);
        tick(6);
        chk({7'h00, hoe}, 8'h01);
        chk(hdo, e);
        bus(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 8'h00);
        tick(6);
        chk({7'h00, cout}, 8'h00);
        op(DPP_OP_PREFIX);
        chk({7'h00, cout}, 8'h00);
        op(DPP_OP_RETURN);
        chk({7'h00, cout}, 8'h01);
        chk({7'h00, iroe}, 8'h00);
    endtask
    initial
    begin
        rst = 1'b1;
        cin = 1'b1;
        bus(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 8'h00);
        void'($urandom(49370));
        tick(16);
        rst = 1'b0;
        tick(5);
        chk({7'h00, cout}, 8'h01);
        wr(1'b1, 1'b0, 8'hA4);
        wr(1'b1, 1'b0, 8'h0F);
        wr(1'b1, 1'b0, 8'h87);
        v = $urandom;
        wr(1'b0, 1'b0, v);
        chk(pdo[0], v);
        chk({7'h00, rdy[0]}, 8'h01);
        rd(1'b0, exp_rd(0, 8'h00));
        chk({7'h00, iroe}, 8'h00);
        p0.pulse(~v, 6);
        tick(3);
        chk({7'h00, rdy[0]}, 8'h00);
        chk({7'h00, iroe}, 8'h01);
        service(8'hA4);
        $display("test output mode done");
        wr(1'b1, 1'b1, 8'h3C);
        wr(1'b1, 1'b1, 8'h4F);
        for (int k = 0; k < 2; k++)
        begin
            wr(1'b1, 1'b1, k ? 8'h83 : 8'h03);
            v = $urandom;
            p1.pulse(v, 4 + 4 * k);
            inl[1] = v;
            tick(3);
            chk({7'h00, rdy[1]}, 8'h00);
            chk({7'h00, iroe}, k[7:0]);
            rd(1'b1, exp_rd(1, 8'h00));
            chk({7'h00, rdy[1]}, 8'h01);
        end
        service(8'h3C);
        $display("test input mode done");
        wr(1'b1, 1'b1, 8'h0F);
        v = $urandom;
        wr(1'b0, 1'b1, v);
        wr(1'b1, 1'b1, 8'h8F);
        rd(1'b1, exp_rd(1, 8'h00));
        $display("test refused mode done");
        for (int k = 0; k < 3; k++)
        begin
            wr(1'b1, 1'b1, 8'hCF);
            r = $urandom;
            o = $urandom;
            l = $urandom;
            wr(1'b1, 1'b1, r);
            wr(1'b0, 1'b1, o);
            p1.drive(l);
            tick(2);
            chk(poe[1], ~r);
            rd(1'b1, exp_rd(1, l));
        end
        wr(1'b1, 1'b1, 8'hCF);
        wr(1'b1, 1'b1, 8'hFF);
        p1.drive(8'h00);
        wr(1'b1, 1'b1, 8'hF7);
        wr(1'b1, 1'b1, 8'hFE);
        p1.drive(8'hFE);
        tick(6);
        chk({7'h00, iroe}, 8'h00);
        p1.drive(8'h01);
        tick(6);
        chk({7'h00, iroe}, 8'h01);
        service(8'h3C);
        $display("test bit mode done");
        report_and_stop();
    end
endmodule // dpp_top_bench
